/* File: led_host_model.sv */
// host controller model driving the serial link and the latch pin
`timescale 1ns/10ps
module led_host_model
    import led_latch_pkg::*;
(
    // link towards the device
    output logic shift_clock,
    output logic serial_in,
    input wire logic serial_out,
    // latch pin
    output logic latch_transfer
);
    initial begin
        shift_clock = 1'h0;
        serial_in = 1'h0;
        latch_transfer = 1'h0;
    end

    // one common clock, idle low between frames, ten edges a word, first bit lands in nine
    task automatic send_word(input chanWord_t w, output chanWord_t seen);
        seen = WORD_RESET;
        #3.3;
        for (int i = LAST_STAGE; i >= 0; i--) begin
            serial_in = w[i];
            #32;
            seen = {seen[LAST_STAGE-1:0], serial_out}; // what a next driver would take
            shift_clock = 1'h1;
            #32;
            shift_clock = 1'h0;
        end
        // released line shows the inverse, never a stale level
        serial_in = ~serial_in;
    endtask : send_word

    // gap first so the last shift has crossed before the latch opens
    task automatic set_latch(input logic lvl);
        #64;
        latch_transfer = lvl;
    endtask : set_latch
endmodule : led_host_model

/* File: led_latch_pkg.sv */
// shared constants and types for the serial led switch latch
package led_latch_pkg;

    // ---------------------------------------------------------------
    // channel word
    // ---------------------------------------------------------------
    localparam int CHAN_COUNT = 10;
    localparam int LAST_STAGE = CHAN_COUNT - 1;
    localparam int FIRST_STAGE = 0;

    typedef logic [CHAN_COUNT-1:0] chanWord_t;

    localparam chanWord_t WORD_RESET = 10'h000;
    localparam chanWord_t WORD_ALL_OFF = 10'h000;

    // ---------------------------------------------------------------
    // control pins, carried together after synchronisation
    // ---------------------------------------------------------------
    typedef struct packed {
        logic latchTransfer;
        logic blank;
        logic overVoltage;
    } ctrlPins_t;

    // blank resets high so that no switch closes before the pins settle
    localparam ctrlPins_t CTRL_RESET = 3'h2;
    localparam int CTRL_WIDTH = 3;

    // ---------------------------------------------------------------
    // crossing and buffering
    // ---------------------------------------------------------------
    localparam int BUF_DEPTH = 2;
    localparam logic TOGGLE_RESET = 1'h0;
    localparam logic BIT_RESET = 1'h0;
    localparam logic RESET_ASSERTED = 1'h1;

    // a pin change counts once the second and third flops agree
    function automatic logic settleBit(input logic stage2, input logic stage3,
                                       input logic held);
        return (stage2 == stage3) ? stage3 : held;
    endfunction : settleBit

endpackage : led_latch_pkg

/* File: serial_led_switch_latch.sv */
// ten-channel serial-in led switch controller with output latch and blanking
//
// Notes on behaviour
// - the channel settings live in a ten-stage serial-in shift register, one stage per switch.
// - each rising shift_clock edge samples serial_in into the first stage and moves all bits on.
// - serial_out shows the last stage, so the stream reappears there ten clocks later.
// - while latch_transfer is high the output latch follows the shift register contents.
// - when latch_transfer falls the latch captures the contents and holds while it stays low.
// - the newest bit drives channel_zero_out and the bit ten clocks old drives channel_nine_out.
// - while blanking is high every switch is off whatever the latch holds.
// - while blanking is low and battery_sense flags no over-voltage each switch follows its own latch bit.
// - a latch bit of zero keeps its switch off and a one keeps it on.
// - reset clears every shift stage so serial_out gives zeros until new data fills it.
// - while battery_sense flags over-voltage every switch is off, and control resumes after.
`timescale 1ns/10ps
module serial_led_switch_latch
    import led_latch_pkg::*;
(
    // core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // serial link, on the host's shift clock
    input wire logic shift_clock,
    input wire logic serial_in,
    output logic serial_out,
    // control pins
    input wire logic latch_transfer,
    input wire logic blank,
    input wire logic battery_sense,
    // switch outputs, high means the switch conducts
    output logic channel_zero_out,
    output logic channel_one_out,
    output logic channel_two_out,
    output logic channel_three_out,
    output logic channel_four_out,
    output logic channel_five_out,
    output logic channel_six_out,
    output logic channel_seven_out,
    output logic channel_eight_out,
    output logic channel_nine_out
);

    // ---------------------------------------------------------------
    // link domain: reset crossing
    // ---------------------------------------------------------------
    // the shift clock only runs when the host sends, so reset reaches
    // the shift register on the fifth link edge after rst rises
    logic linkRstMeta_q, linkRstMeta_d;
    logic linkRst2_q, linkRst2_d;
    logic linkRst3_q, linkRst3_d;
    logic linkRst_q, linkRst_d;

    always_comb begin
        linkRstMeta_d = rst;
        linkRst2_d = linkRstMeta_q;
        linkRst3_d = linkRst2_q;
        linkRst_d = settleBit(linkRst2_q, linkRst3_q, linkRst_q);
    end

    always_ff @(posedge shift_clock) begin
        linkRstMeta_q <= linkRstMeta_d;
        linkRst2_q <= linkRst2_d;
        linkRst3_q <= linkRst3_d;
        linkRst_q <= linkRst_d;
    end

    // ---------------------------------------------------------------
    // link domain: shift register
    // ---------------------------------------------------------------
    chanWord_t shiftReg_q, shiftReg_d;
    logic shiftToggle_q, shiftToggle_d;

    always_comb begin
        shiftReg_d = shiftReg_q;
        shiftToggle_d = shiftToggle_q;
        if (linkRst_q == RESET_ASSERTED) begin
            shiftReg_d = WORD_RESET;
            shiftToggle_d = TOGGLE_RESET;
        end else begin
            // bit 0 is always the newest sample, bit 9 the oldest
            shiftReg_d = {shiftReg_q[LAST_STAGE-1:FIRST_STAGE], serial_in};
            // one toggle per shift tells the core a new word stands
            shiftToggle_d = ~shiftToggle_q;
        end
    end

    always_ff @(posedge shift_clock) begin
        shiftReg_q <= shiftReg_d;
        shiftToggle_q <= shiftToggle_d;
    end

    // the daisy-chain output is a flop of the link domain
    assign serial_out = shiftReg_q[LAST_STAGE];

    // ---------------------------------------------------------------
    // core domain: pin synchronisers
    // ---------------------------------------------------------------
    ctrlPins_t pinsRaw;
    ctrlPins_t pinsMeta_q, pinsMeta_d;
    ctrlPins_t pins2_q, pins2_d;
    ctrlPins_t pins3_q, pins3_d;
    ctrlPins_t ctrl_q, ctrl_d;

    assign pinsRaw.latchTransfer = latch_transfer;
    assign pinsRaw.blank = blank;
    assign pinsRaw.overVoltage = battery_sense;

    always_comb begin
        logic [CTRL_WIDTH-1:0] held;
        logic [CTRL_WIDTH-1:0] s2;
        logic [CTRL_WIDTH-1:0] s3;
        held = ctrl_q;
        s2 = pins2_q;
        s3 = pins3_q;
        pinsMeta_d = pinsRaw;
        pins2_d = pinsMeta_q;
        pins3_d = pins2_q;
        // each pin settles on its own, so a slow edge on one holds back no other
        for (int i = 0; i < CTRL_WIDTH; i++) begin
            held[i] = settleBit(s2[i], s3[i], held[i]);
        end
        ctrl_d = held;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinsMeta_q <= CTRL_RESET;
            pins2_q <= CTRL_RESET;
            pins3_q <= CTRL_RESET;
            ctrl_q <= CTRL_RESET;
        end else begin
            pinsMeta_q <= pinsMeta_d;
            pins2_q <= pins2_d;
            pins3_q <= pins3_d;
            ctrl_q <= ctrl_d;
        end
    end

    // ---------------------------------------------------------------
    // core domain: shift toggle synchroniser
    // ---------------------------------------------------------------
    logic togMeta_q, togMeta_d;
    logic tog2_q, tog2_d;
    logic tog3_q, tog3_d;
    logic togSeen_q, togSeen_d;

    always_comb begin
        togMeta_d = shiftToggle_q;
        tog2_d = togMeta_q;
        tog3_d = tog2_q;
        togSeen_d = settleBit(tog2_q, tog3_q, togSeen_q);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            togMeta_q <= TOGGLE_RESET;
            tog2_q <= TOGGLE_RESET;
            tog3_q <= TOGGLE_RESET;
            togSeen_q <= TOGGLE_RESET;
        end else begin
            togMeta_q <= togMeta_d;
            tog2_q <= tog2_d;
            tog3_q <= tog3_d;
            togSeen_q <= togSeen_d;
        end
    end

    // ---------------------------------------------------------------
    // core domain: word capture into the buffer
    // ---------------------------------------------------------------
    // the shift register is read only once its toggle has settled, at
    // least two core cycles after the link edge, so it is quiet then;
    // a stall longer than one link period could merge two shifts, which
    // is harmless since only the newest word matters to the latch
    logic togTaken_q, togTaken_d;
    logic wordPending;
    logic bufInReady;
    logic bufOutValid;
    logic bufOutReady;
    chanWord_t bufOutWord;

    assign wordPending = (togSeen_q != togTaken_q);

    always_comb begin
        togTaken_d = togTaken_q;
        if (wordPending && bufInReady) begin
            togTaken_d = togSeen_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            togTaken_q <= TOGGLE_RESET;
        end else begin
            togTaken_q <= togTaken_d;
        end
    end

    word_buffer #(
        .DEPTH(BUF_DEPTH)
    ) wordBuf (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(wordPending),
        .inWord(shiftReg_q),
        .inReady(bufInReady),
        .outValid(bufOutValid),
        .outWord(bufOutWord),
        .outReady(bufOutReady)
    );

    // ---------------------------------------------------------------
    // core domain: mirror of the shift register and output latch
    // ---------------------------------------------------------------
    chanWord_t mirror_q, mirror_d;
    chanWord_t latch_q, latch_d;
    logic latchPrev_q, latchPrev_d;
    logic latchFall;

    assign latchFall = latchPrev_q && !ctrl_q.latchTransfer;
    // the mirror is frozen in the capture cycle so the falling edge
    // takes exactly what the transparent latch last showed
    assign bufOutReady = !latchFall;

    always_comb begin
        mirror_d = mirror_q;
        if (bufOutValid && bufOutReady) begin
            mirror_d = bufOutWord;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mirror_q <= WORD_RESET;
        end else begin
            mirror_q <= mirror_d;
        end
    end

    // the latch works on the synced level, a few core cycles behind the pin
    always_comb begin
        latch_d = latch_q;
        latchPrev_d = ctrl_q.latchTransfer;
        if (ctrl_q.latchTransfer) begin
            latch_d = mirror_q;
        end else if (latchFall) begin
            latch_d = mirror_q;
        end else begin
            latch_d = latch_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            latch_q <= WORD_RESET;
            latchPrev_q <= BIT_RESET;
        end else begin
            latch_q <= latch_d;
            latchPrev_q <= latchPrev_d;
        end
    end

    // ---------------------------------------------------------------
    // core domain: switch drive
    // ---------------------------------------------------------------
    chanWord_t switch_q, switch_d;

    always_comb begin
        if (ctrl_q.blank) begin
            switch_d = WORD_ALL_OFF;
        end else if (ctrl_q.overVoltage) begin
            switch_d = WORD_ALL_OFF;
        end else begin
            switch_d = latch_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            switch_q <= WORD_ALL_OFF;
        end else begin
            switch_q <= switch_d;
        end
    end

    // ---------------------------------------------------------------
    // channel mapping, newest bit to channel zero
    // ---------------------------------------------------------------
    assign channel_zero_out = switch_q[0];
    assign channel_one_out = switch_q[1];
    assign channel_two_out = switch_q[2];
    assign channel_three_out = switch_q[3];
    assign channel_four_out = switch_q[4];
    assign channel_five_out = switch_q[5];
    assign channel_six_out = switch_q[6];
    assign channel_seven_out = switch_q[7];
    assign channel_eight_out = switch_q[8];
    assign channel_nine_out = switch_q[LAST_STAGE];

endmodule : serial_led_switch_latch

/* File: serial_led_switch_latch_assertions.sv */
// concurrent checks on the ports of the serial led switch latch
`timescale 1ns/10ps
module serial_led_switch_latch_chk
    import led_latch_pkg::*;
(
    // clocks and reset
    input wire logic core_clk,
    input wire logic rst,
    // link
    input wire logic shift_clock,
    input wire logic serial_in,
    input wire logic serial_out,
    // control pins
    input wire logic latch_transfer,
    input wire logic blank,
    input wire logic battery_sense,
    // switches
    input wire logic channel_zero_out,
    input wire logic channel_one_out,
    input wire logic channel_two_out,
    input wire logic channel_three_out,
    input wire logic channel_four_out,
    input wire logic channel_five_out,
    input wire logic channel_six_out,
    input wire logic channel_seven_out,
    input wire logic channel_eight_out,
    input wire logic channel_nine_out
);
    chanWord_t chans;
    logic [5:0] linkCnt_q, linkCnt_d;
    logic [4:0] quietCnt_q, quietCnt_d;
    logic clkSeen_q;

    assign chans = {channel_nine_out, channel_eight_out, channel_seven_out, channel_six_out,
        channel_five_out, channel_four_out, channel_three_out, channel_two_out,
        channel_one_out, channel_zero_out};

    // ---------------------------------------------------------------
    // helper counters
    // ---------------------------------------------------------------
    // quiet time: latch open, nothing blanking, no shift edge seen by the core
    always_comb begin
        linkCnt_d = (linkCnt_q == 6'h3F) ? linkCnt_q : linkCnt_q + 6'h01;
        quietCnt_d = (quietCnt_q == 5'h1F) ? quietCnt_q : quietCnt_q + 5'h01;
        if (!latch_transfer || blank || battery_sense || (shift_clock && !clkSeen_q)) begin
            quietCnt_d = 5'h00;
        end
    end
    always_ff @(posedge shift_clock) begin
        linkCnt_q <= rst ? 6'h00 : linkCnt_d;
    end
    always_ff @(posedge core_clk) begin
        quietCnt_q <= rst ? 5'h00 : quietCnt_d;
        clkSeen_q <= shift_clock;
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    AST_RESET_OFF: assert property (@(posedge core_clk) rst |=> chans == WORD_ALL_OFF)
        else $error("switches on during reset");
    AST_SERIAL_RESET_ZERO: assert property (@(posedge shift_clock) rst [*8] |-> !serial_out)
        else $error("serial output not cleared by reset");
    AST_SERIAL_DELAY: assert property (@(posedge shift_clock) disable iff (rst)
        linkCnt_q >= 6'h14 |-> serial_out == $past(serial_in, 10))
        else $error("serial output is not the input ten edges late");
    AST_BLANK_TIMELY: assert property (@(posedge core_clk) disable iff (rst)
        $rose(blank) |-> ##[1:6] chans == WORD_ALL_OFF)
        else $error("blanking did not turn switches off");
    AST_OVERVOLT_TIMELY: assert property (@(posedge core_clk) disable iff (rst)
        $rose(battery_sense) |-> ##[1:6] chans == WORD_ALL_OFF)
        else $error("over-voltage did not turn switches off");
    AST_OFF_HELD: assert property (@(posedge core_clk) disable iff (rst)
        (blank || battery_sense) [*6] |-> chans == WORD_ALL_OFF)
        else $error("switch on while disabled");
    AST_LATCH_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        (!latch_transfer && !blank && !battery_sense) [*8] |=> $stable(chans))
        else $error("switches moved while latch closed");
    AST_CHAN_NINE: assert property (@(posedge core_clk) disable iff (rst)
        quietCnt_q >= 5'h0C |-> channel_nine_out == serial_out)
        else $error("channel nine differs from last stage");

    cover property (@(posedge core_clk) disable iff (rst) $fell(latch_transfer));
    cover property (@(posedge core_clk) disable iff (rst) quietCnt_q >= 5'h0C);
    cover property (@(posedge core_clk) disable iff (rst) $rose(battery_sense));
endmodule : serial_led_switch_latch_chk

bind serial_led_switch_latch serial_led_switch_latch_chk chk (.core_clk(core_clk), .rst(rst),
    .shift_clock(shift_clock), .serial_in(serial_in), .serial_out(serial_out),
    .latch_transfer(latch_transfer), .blank(blank), .battery_sense(battery_sense),
    .channel_zero_out(channel_zero_out), .channel_one_out(channel_one_out),
    .channel_two_out(channel_two_out), .channel_three_out(channel_three_out),
    .channel_four_out(channel_four_out), .channel_five_out(channel_five_out),
    .channel_six_out(channel_six_out), .channel_seven_out(channel_seven_out),
    .channel_eight_out(channel_eight_out), .channel_nine_out(channel_nine_out));

/* File: serial_led_switch_latch_tb.sv */
// self-checking testbench for the serial led switch latch
`timescale 1ns/10ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", what, exp, got); end end
module serial_led_switch_latch_tb
    import led_latch_pkg::*;
;
    logic core_clk = 1'h0;
    logic rst;
    logic blank;
    logic battery_sense;
    wire logic shift_clock, serial_in, serial_out, latch_transfer;
    wire chanWord_t chans;
    chanWord_t seen;
    int mismatches = 0;
    int samples_checked = 0;

    always #4 core_clk = ~core_clk;

    led_host_model host (.shift_clock(shift_clock), .serial_in(serial_in),
        .serial_out(serial_out), .latch_transfer(latch_transfer));
    serial_led_switch_latch dut (.core_clk(core_clk), .rst(rst), .shift_clock(shift_clock),
        .serial_in(serial_in), .serial_out(serial_out), .latch_transfer(latch_transfer),
        .blank(blank), .battery_sense(battery_sense), .channel_zero_out(chans[0]),
        .channel_one_out(chans[1]), .channel_two_out(chans[2]), .channel_three_out(chans[3]),
        .channel_four_out(chans[4]), .channel_five_out(chans[5]), .channel_six_out(chans[6]),
        .channel_seven_out(chans[7]), .channel_eight_out(chans[8]),
        .channel_nine_out(chans[9]));

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic wrap_up();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_latch_hold();
        host.send_word(10'h2A5, seen);
        cyc(12);
        `CHK("closed latch", WORD_ALL_OFF, chans)
        host.set_latch(1'h1);
        host.set_latch(1'h0);
        cyc(12);
        `CHK("latched word", 10'h2A5, chans)
    endtask : t_latch_hold

    task automatic t_stream();
        host.send_word(10'h3FF, seen);
        `CHK("serial out", 10'h2A5, seen)
        host.send_word(10'h001, seen);
        `CHK("serial out", 10'h3FF, seen)
        host.set_latch(1'h1);
        host.set_latch(1'h0);
        cyc(12);
        `CHK("newest bit", 10'h001, chans)
    endtask : t_stream

    task automatic t_disable();
        blank = 1'h1;
        cyc(8);
        `CHK("blanked", WORD_ALL_OFF, chans)
        blank = 1'h0;
        cyc(8);
        `CHK("unblanked", 10'h001, chans)
        battery_sense = 1'h1;
        cyc(8);
        `CHK("over-voltage", WORD_ALL_OFF, chans)
        blank = 1'h1;
        battery_sense = 1'h0;
        cyc(8);
        `CHK("still blanked", WORD_ALL_OFF, chans)
        blank = 1'h0;
        cyc(8);
        `CHK("resumed", 10'h001, chans)
    endtask : t_disable

    task automatic t_transparent();
        host.set_latch(1'h1);
        host.send_word(10'h155, seen);
        cyc(12);
        `CHK("open latch", 10'h155, chans)
        host.set_latch(1'h0);
        host.send_word(10'h0F0, seen);
        `CHK("serial out", 10'h155, seen)
        cyc(12);
        `CHK("held word", 10'h155, chans)
    endtask : t_transparent

    task automatic t_reset();
        // link reset needs shift edges too, so reset spans a zero frame
        rst = 1'h1;
        blank = 1'h1;
        battery_sense = 1'h0;
        fork
            host.send_word(WORD_RESET, seen);
            cyc(80);
        join
        cyc(1);
        rst = 1'h0;
        cyc(2);
        `CHK("reset switches", WORD_ALL_OFF, chans)
        `CHK("reset serial out", 1'h0, serial_out)
        host.send_word(WORD_RESET, seen);
        host.send_word(WORD_RESET, seen);
        `CHK("zeros after reset", WORD_RESET, seen)
        cyc(1);
        blank = 1'h0;
        cyc(8);
    endtask : t_reset

    // a reset in mid-run must clear a register that holds ones
    task automatic t_mid_reset();
        rst = 1'h1;
        fork
            host.send_word(10'h3FF, seen);
            cyc(80);
        join
        cyc(1);
        `CHK("mid reset serial out", 1'h0, serial_out)
        `CHK("mid reset switches", WORD_ALL_OFF, chans)
        rst = 1'h0;
        host.send_word(10'h2A5, seen);
        `CHK("zeros after mid reset", WORD_RESET, seen)
    endtask : t_mid_reset

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        t_reset();
        t_latch_hold();
        t_stream();
        t_disable();
        t_transparent();
        t_mid_reset();
        wrap_up();
    end

    // about ten frames of 640 ns plus waits; some thirteen times that is ample
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
endmodule : serial_led_switch_latch_tb

/* File: word_buffer.sv */
// two-entry valid/ready buffer for channel words
`timescale 1ns/10ps
module word_buffer
    import led_latch_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // filling side
    input wire logic inValid,
    input chanWord_t inWord,
    output logic inReady,
    // draining side
    output logic outValid,
    output chanWord_t outWord,
    input wire logic outReady
);

    // ---------------------------------------------------------------
    // storage and pointers
    // ---------------------------------------------------------------
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    chanWord_t mem_q [DEPTH];
    chanWord_t mem_d [DEPTH];
    logic [PW-1:0] wrPtr_q, wrPtr_d;
    logic [PW-1:0] rdPtr_q, rdPtr_d;
    logic [CW-1:0] count_q, count_d;
    logic push;
    logic pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] ptr);
        return (ptr == PW'(DEPTH - 1)) ? '0 : ptr + PW'(1);
    endfunction : bump

    // ---------------------------------------------------------------
    // handshakes
    // ---------------------------------------------------------------
    assign inReady = (count_q != CW'(DEPTH));
    assign outValid = (count_q != '0);
    assign outWord = mem_q[rdPtr_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        mem_d = mem_q;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (push) begin
            mem_d[wrPtr_q] = inWord;
            wrPtr_d = bump(wrPtr_q);
        end
        if (pop) begin
            rdPtr_d = bump(rdPtr_q);
        end
        if (push && !pop) begin
            count_d = count_q + CW'(1);
        end else if (pop && !push) begin
            count_d = count_q - CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= WORD_RESET;
            end
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            mem_q <= mem_d;
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

endmodule : word_buffer
